// file: kyp_keypad_link.sv
// Key scan, key read request and serial key readout with an Avalon-MM register slave.
// Overview of operation
// - Select bit set: working clock comes from the external clock on the timing pin.
// - Select bit clear: working clock comes from the internal RC oscillator.
// - Two matching scans finish key scanning in 615 working clock periods.
// - Mismatching scans repeat, so the whole scan takes 1230 periods.
// - A pending key read request pulls the data output low while enable is low.
// - A read without a pending request returns invalid key and sleep bits.
// - During system reset the data output stays high, even on a read.
module kyp_keypad_link #(
  parameter int RC_DIV = kyp_pkg::RC_DIV_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire kyp_pkg::kyp_link_s link_in,
  input wire logic external_reset_n,
  input wire logic osc_ext_clk,
  input wire logic [kyp_pkg::KEY_W-1:0] key_state_bits,
  output logic serial_out_o,
  output logic serial_out_oe
);

  localparam int SYNC_W = kyp_pkg::KEY_W + 5;

  // Byte-lane merge used for every writable register.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // All pins from outside the clock domain pass two flops first.
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  kyp_pkg::kyp_link_s link_s;
  logic ext_rst_n_s;
  logic osc_s;
  logic [kyp_pkg::KEY_W-1:0] keys_s;

  assign sync_in = {external_reset_n, osc_ext_clk, key_state_bits, link_in};
  assign {ext_rst_n_s, osc_s, keys_s, link_s} = sync_out;

  kyp_sync #(.W(SYNC_W)) u_sync (
    .clock(clock),
    .rst(rst),
    .d(sync_in),
    .q(sync_out)
  );

  // Register state.
  logic [kyp_pkg::CTRL_W-1:0] ctrl_q;
  logic [kyp_pkg::IRQ_W-1:0] irq_st_q;
  logic [kyp_pkg::IRQ_W-1:0] irq_en_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic irq_q;

  // Scan and link state.
  kyp_pkg::kyp_scan_e sc_state_q;
  logic [9:0] sc_cnt_q;
  logic [10:0] tot_q;
  logic retry_q;
  logic [kyp_pkg::KEY_W-1:0] first_q;
  logic [kyp_pkg::KEY_W-1:0] key_buf_q;
  logic req_q;
  logic [7:0] rc_cnt_q;
  logic osc_prev_q;
  logic ce_prev_q;
  logic cl_prev_q;
  logic [7:0] addr_q;
  logic reading_q;
  logic [kyp_pkg::READ_BITS-1:0] out_q;
  logic [kyp_pkg::DISP_W-1:0] disp_cnt_q;
  logic oe_q;

  // Device reset comes from the synchronised reset pin.
  wire dev_rst = !ext_rst_n_s;
  wire src_ext = ctrl_q[kyp_pkg::CTRL_SRC_BIT];
  wire scan_en = ctrl_q[kyp_pkg::CTRL_SCAN_BIT];
  wire sleep_ack_bit = ctrl_q[kyp_pkg::CTRL_SLEEP_BIT];

  // Working clock tick: external edge or RC divider, stopped during reset.
  wire rc_tick = (rc_cnt_q == 8'(RC_DIV - 1));
  wire ext_tick = osc_s && !osc_prev_q;
  wire tick = !dev_rst && (src_ext ? ext_tick : rc_tick);

  // Scan sequencing terms.
  wire any_key = |keys_s;
  wire scan_start = (sc_state_q == kyp_pkg::SC_IDLE) && scan_en && !dev_rst && !req_q && any_key;
  wire pass_end = (sc_state_q == kyp_pkg::SC_SCAN) && tick && (sc_cnt_q == kyp_pkg::SCAN_PERIODS - 10'd1);
  wire keys_match = (keys_s == first_q);
  wire scan_done = pass_end && (keys_match || retry_q);
  wire scan_retry = pass_end && !keys_match && !retry_q;

  // Serial link edge detection on synchronised pins.
  wire ce = link_s.enable;
  wire ce_rise = ce && !ce_prev_q;
  wire ce_fall = !ce && ce_prev_q;
  wire cl_rise = link_s.shift_clk && !cl_prev_q;
  wire cl_fall = !link_s.shift_clk && cl_prev_q;
  wire read_start = ce_rise && (addr_q == kyp_pkg::ADDR_KEY_READ);
  wire read_done = ce_fall && reading_q;
  wire disp_done = ce_fall && !reading_q && (addr_q == kyp_pkg::ADDR_DISPLAY);

  // A read with no request pending returns zeros, marking the data as invalid.
  wire [kyp_pkg::READ_BITS-1:0] read_word = req_q ? {sleep_ack_bit, key_buf_q} : '0;

  // Open-drain drive: reset keeps the line high, a read shifts data, idle shows the request.
  wire oe_d = dev_rst ? 1'b0 : (reading_q ? !out_q[0] : (!ce && req_q));

  // Bus decode.
  wire bus_fire = (avs_read || avs_write) && !wait_q;
  wire wr_fire = avs_write && !wait_q;
  wire wr_ctrl = wr_fire && (avs_address == kyp_pkg::OFF_CTRL);
  wire wr_en = wr_fire && (avs_address == kyp_pkg::OFF_IRQ_EN);
  wire wr_clr = wr_fire && (avs_address == kyp_pkg::OFF_IRQ_CLR);
  wire [31:0] ctrl_wr = be_merge({29'h0, ctrl_q}, avs_writedata, avs_byteenable);
  wire [31:0] en_wr = be_merge({29'h0, irq_en_q}, avs_writedata, avs_byteenable);
  wire [31:0] clr_wr = be_merge(32'h0, avs_writedata, avs_byteenable);
  wire [kyp_pkg::IRQ_W-1:0] irq_evt = {read_done, scan_retry, scan_done};
  wire [4:0] status_word = {retry_q, sc_state_q == kyp_pkg::SC_SCAN, reading_q, dev_rst, req_q};

  // Read mux; unmapped offsets and the clear register read as zero.
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0;
    unique case (avs_address)
      kyp_pkg::OFF_CTRL: rdata_d = {29'h0, ctrl_q};
      kyp_pkg::OFF_STATUS: rdata_d = {27'h0, status_word};
      kyp_pkg::OFF_KEYS: rdata_d = {2'h0, key_buf_q};
      kyp_pkg::OFF_IRQ_ST: rdata_d = {29'h0, irq_st_q};
      kyp_pkg::OFF_IRQ_EN: rdata_d = {29'h0, irq_en_q};
      kyp_pkg::OFF_DISP: rdata_d = {16'h0, disp_cnt_q};
      default: rdata_d = 32'h0;
    endcase
  end

  // Avalon handshake: one wait cycle, then the answer stands for one cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= rdata_d;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Software registers; a set event wins over a same-cycle clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= kyp_pkg::CTRL_RESET;
      irq_en_q <= kyp_pkg::IRQ_EN_RESET;
      irq_st_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wr[kyp_pkg::CTRL_W-1:0];
      end
      if (wr_en) begin
        irq_en_q <= en_wr[kyp_pkg::IRQ_W-1:0];
      end
      irq_st_q <= (irq_st_q & ~(wr_clr ? clr_wr[kyp_pkg::IRQ_W-1:0] : '0)) | irq_evt;
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  // Working clock source: RC divider runs only in RC mode and outside reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rc_cnt_q <= 8'h00;
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
      if (dev_rst || src_ext || rc_tick) begin
        rc_cnt_q <= 8'h00;
      end else begin
        rc_cnt_q <= rc_cnt_q + 8'h01;
      end
    end
  end

  // Key scan: one 615-period pass, and a second pass when the two samples disagree.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sc_state_q <= kyp_pkg::SC_IDLE;
      sc_cnt_q <= 10'h000;
      tot_q <= 11'h000;
      retry_q <= 1'b0;
      first_q <= '0;
      key_buf_q <= '0;
    end else if (dev_rst) begin
      sc_state_q <= kyp_pkg::SC_IDLE;
      retry_q <= 1'b0;
      key_buf_q <= '0;
    end else begin
      unique case (sc_state_q)
        kyp_pkg::SC_IDLE: begin
          if (scan_start) begin
            sc_state_q <= kyp_pkg::SC_SCAN;
            sc_cnt_q <= 10'h000;
            tot_q <= 11'h000;
            retry_q <= 1'b0;
            first_q <= keys_s;
          end
        end
        kyp_pkg::SC_SCAN: begin
          if (tick) begin
            tot_q <= tot_q + 11'h001;
          end
          if (scan_done) begin
            sc_state_q <= kyp_pkg::SC_IDLE;
            key_buf_q <= keys_s;
          end else if (scan_retry) begin
            retry_q <= 1'b1;
            first_q <= keys_s;
            sc_cnt_q <= 10'h000;
          end else if (tick) begin
            sc_cnt_q <= sc_cnt_q + 10'h001;
          end
        end
      endcase
    end
  end

  // Read request: raised by a finished scan, dropped by a completed read.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
    end else if (dev_rst) begin
      req_q <= 1'b0;
    end else if (scan_done) begin
      req_q <= 1'b1;
    end else if (read_done) begin
      req_q <= 1'b0;
    end
  end

  // Serial interface is never cleared by device reset, so transfers go on during it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ce_prev_q <= 1'b0;
      cl_prev_q <= 1'b0;
      addr_q <= 8'h00;
      reading_q <= 1'b0;
      out_q <= '0;
      disp_cnt_q <= '0;
    end else begin
      ce_prev_q <= ce;
      cl_prev_q <= link_s.shift_clk;
      if (cl_rise && !ce) begin
        addr_q <= {link_s.data_in, addr_q[7:1]};
      end
      if (read_start) begin
        reading_q <= 1'b1;
        out_q <= read_word;
      end else if (ce_fall) begin
        reading_q <= 1'b0;
      end else if (cl_fall && reading_q) begin
        out_q <= {1'b1, out_q[kyp_pkg::READ_BITS-1:1]};
      end
      if (disp_done) begin
        disp_cnt_q <= disp_cnt_q + 16'h0001;
      end
    end
  end

  // Pin drive register; the output value is always low, only the enable moves.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign irq = irq_q;
  assign serial_out_oe = oe_q;
  assign serial_out_o = 1'b0;

  // Checks on the design's own behaviour.
  property p_ext_src;
    @(posedge clock) disable iff (rst)
    (src_ext && !dev_rst) |-> (tick == ext_tick) ##1 (rc_cnt_q == 8'h00);
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("tick without external edge in external mode");

  property p_rc_src;
    @(posedge clock) disable iff (rst)
    (tick && !src_ext) |-> (rc_cnt_q == 8'(RC_DIV - 1)) ##1 (rc_cnt_q == 8'h00);
  endproperty
  a_rc_src: assert property (p_rc_src) else $error("RC tick not at divider end");

  property p_scan_short;
    @(posedge clock) disable iff (rst)
    (scan_done && !retry_q) |-> (tot_q == 11'(kyp_pkg::SCAN_PERIODS - 10'd1));
  endproperty
  a_scan_short: assert property (p_scan_short) else $error("matching scan not 615 periods");

  property p_scan_long;
    @(posedge clock) disable iff (rst)
    (scan_done && retry_q) |-> (tot_q == kyp_pkg::RESCAN_PERIODS - 11'd1);
  endproperty
  a_scan_long: assert property (p_scan_long) else $error("repeated scan not 1230 periods");

  property p_req_low;
    @(posedge clock) disable iff (rst)
    (req_q && !ce && !reading_q && !dev_rst) |=> oe_q;
  endproperty
  a_req_low: assert property (p_req_low) else $error("pending request not driven low");

  property p_invalid;
    @(posedge clock) disable iff (rst)
    (read_start && !req_q) |=> (out_q == '0) && reading_q;
  endproperty
  a_invalid: assert property (p_invalid) else $error("read without request not invalid");

  property p_reset_high;
    @(posedge clock) disable iff (rst)
    dev_rst |=> !oe_q;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("output driven during reset");

  property p_release;
    @(posedge clock) disable iff (rst)
    (read_done && !scan_done) |=> !req_q ##1 (!oe_q || reading_q || ce);
  endproperty
  a_release: assert property (p_release) else $error("request not released after read");

  property p_irq;
    @(posedge clock) disable iff (rst)
    (scan_done && irq_en_q[kyp_pkg::IRQ_REQ_BIT] && !wr_en) |-> ##2 irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled request event gave no interrupt");

endmodule : kyp_keypad_link

// file: kyp_pkg.sv
// Shared constants, register map and types for the key read request block.
package kyp_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_KEYS = 6'h08;
  localparam logic [5:0] OFF_IRQ_ST = 6'h0C;
  localparam logic [5:0] OFF_IRQ_EN = 6'h10;
  localparam logic [5:0] OFF_IRQ_CLR = 6'h14;
  localparam logic [5:0] OFF_DISP = 6'h18;

  // Control register fields and reset value.
  localparam int CTRL_W = 3;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_SCAN_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  // Status register fields.
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_RST_BIT = 1;
  localparam int STAT_READ_BIT = 2;
  localparam int STAT_SCAN_BIT = 3;
  localparam int STAT_RETRY_BIT = 4;

  // Interrupt event bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_REQ_BIT = 0;
  localparam int IRQ_RETRY_BIT = 1;
  localparam int IRQ_READ_BIT = 2;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;

  // Key data widths.
  localparam int KEY_W = 30;
  localparam int READ_BITS = 31;
  localparam int DISP_W = 16;

  // Scan timing in working clock periods.
  localparam logic [9:0] SCAN_PERIODS = 10'd615;
  localparam logic [10:0] RESCAN_PERIODS = 11'(2 * 615);

  // Serial link bus addresses.
  localparam logic [7:0] ADDR_DISPLAY = 8'h42;
  localparam logic [7:0] ADDR_KEY_READ = 8'h43;

  // Default internal oscillator divider, in system clocks per period.
  localparam int RC_DIV_DEFAULT = 8;

  // Serial link pins from the controller.
  typedef struct packed {
    logic enable;
    logic shift_clk;
    logic data_in;
  } kyp_link_s;

  typedef enum logic {
    SC_IDLE,
    SC_SCAN
  } kyp_scan_e;

endpackage : kyp_pkg

// file: kyp_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs.
module kyp_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : kyp_sync

// file: kyp_host_model.sv
// Host controller model that drives the serial link and samples the key request line.
module kyp_host_model (
  input wire logic clock,
  input wire logic serial_line,
  output kyp_pkg::kyp_link_s link
);
  timeunit 1ns;
  timeprecision 1ps;

  // The link is idle at power up: enable low, shift clock parked low.
  initial link = '{enable: 1'b0, shift_clk: 1'b0, data_in: 1'b0};

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold

  // Shift an 8-bit bus address LSB first with enable low, then raise enable.
  task automatic send_addr(input logic [7:0] a);
    for (int i = 0; i < 8; i++) begin
      link.data_in <= a[i];
      hold(12);
      link.shift_clk <= 1'b1;
      hold(13);
      link.shift_clk <= 1'b0;
    end
    link.data_in <= ~a[7]; // No pull on this line, so a released line must not keep the last bit.
    hold(12);
    link.enable <= 1'b1;
    hold(12);
  endtask : send_addr

  // Read the 31-bit key word, bit0 first, sampling the line just before each rising shift edge.
  task automatic key_read(output logic [30:0] w);
    send_addr(kyp_pkg::ADDR_KEY_READ);
    for (int i = 0; i < kyp_pkg::READ_BITS; i++) begin
      w[i] = serial_line;
      link.shift_clk <= 1'b1;
      hold(13);
      link.shift_clk <= 1'b0;
      hold(12);
    end
    link.enable <= 1'b0;
    hold(12);
  endtask : key_read

  // Timer polling: look at the request line once per period, only while enable is low.
  task automatic timer_poll(input int period, input int tries, output int k);
    k = 0;
    while (k < tries && !(serial_line === 1'b0 && !link.enable)) begin
      hold(period);
      k++;
    end
  endtask : timer_poll

  // Display refresh split into groups; each group is far shorter than 30 ms.
  task automatic disp_refresh(input int groups);
    repeat (groups) begin
      send_addr(kyp_pkg::ADDR_DISPLAY);
      link.enable <= 1'b0;
      hold(12);
    end
  endtask : disp_refresh
endmodule : kyp_host_model

// file: test_kyp_keypad_link.sv
// Self-checking bench for the key read request block driven by the host model.
module test_kyp_keypad_link;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  localparam int SCAN = 615 * DIV;
  localparam logic [29:0] K1 = 30'h2AAA5555;
  localparam logic [29:0] K2 = 30'h000000F1;
  localparam logic [29:0] K3 = 30'h12345678;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  kyp_pkg::kyp_link_s link;
  logic external_reset_n = 1'b0;
  logic osc_ext_clk = 1'b0;
  logic osc_run = 1'b0;
  logic [29:0] keys = 30'h0;
  logic serial_out_o;
  logic serial_out_oe;
  wire serial_line;
  logic [30:0] w;
  int n;
  int fail_count = 0;
  int n_checks = 0;

  // Open-drain line with a pull-up: low only while the block pulls it.
  assign serial_line = serial_out_oe ? serial_out_o : 1'b1;
  always #2.5 clock = ~clock;
  // External timing clock, gated so that its absence can be seen.
  always @(posedge clock) if (osc_run) osc_ext_clk <= ~osc_ext_clk;

  kyp_keypad_link #(.RC_DIV(DIV)) u_dut (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link_in(link), .external_reset_n(external_reset_n),
    .osc_ext_clk(osc_ext_clk), .key_state_bits(keys), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe)
  );
  kyp_host_model u_host (.clock(clock), .serial_line(serial_line), .link(link));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] in_win(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction : in_win

  // One Avalon access held until waitrequest is sampled low; an extra edge keeps strobes apart.
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      if (k == 100) begin
        fail_count++;
        summarize();
      end
      @(posedge clock);
      k++;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : acc

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    acc(1'b0, a, 32'h0, v);
    chk(nm, v & m, e);
  endtask : rchk

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] v;
    acc(1'b1, a, d, v);
  endtask : wreg

  // Poll the request line every clock, giving up after lim cycles.
  task automatic wait_low(input int lim, output int c);
    c = 0;
    while (serial_line !== 1'b0 && c < lim) begin
      @(posedge clock);
      c++;
    end
  endtask : wait_low

  // Main sequence: reset, device reset, RC scan and rescan with interrupts, external scans, display count.
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rchk("ctrl reset", kyp_pkg::OFF_CTRL, 32'h7, 32'h2);
    rchk("irq enable reset", kyp_pkg::OFF_IRQ_EN, 32'h7, 32'h0);
    rchk("unmapped", 6'h3C, 32'hFFFFFFFF, 32'h0);
    wreg(kyp_pkg::OFF_STATUS, 32'hFFFFFFFF);
    rchk("status in reset", kyp_pkg::OFF_STATUS, 32'h3, 32'h2);
    keys <= K1;
    wait_low(3000, n);
    chk("line in reset", 32'(n), 32'd3000);
    u_host.key_read(w);
    chk("read in reset", {1'b0, w}, 32'h7FFFFFFF);
    wreg(kyp_pkg::OFF_IRQ_EN, 32'h1);
    external_reset_n <= 1'b1;
    wait_low(SCAN + 100, n);
    chk("rc scan time", in_win(n, SCAN, SCAN + 30), 32'h1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rchk("request pending", kyp_pkg::OFF_STATUS, 32'h1, 32'h1);
    keys <= 30'h0;
    u_host.key_read(w);
    chk("key word", {1'b0, w}, {2'b00, K1});
    wreg(kyp_pkg::OFF_IRQ_CLR, 32'h7);
    rchk("irq cleared", kyp_pkg::OFF_IRQ_ST, 32'h7, 32'h0);
    chk("irq low", {31'h0, irq}, 32'h0);
    // The line is watched every clock for more than a full rescan time.
    wait_low(2 * SCAN + 100, n);
    chk("request released", 32'(n), 32'(2 * SCAN + 100));
    u_host.key_read(w);
    chk("read without request", {1'b0, w}, 32'h0);
    // Keys change during the first pass, forcing a second pass.
    keys <= K2;
    repeat (600) @(posedge clock);
    keys <= K3;
    wait_low(3000, n);
    chk("rescan time", in_win(n + 600, 2 * SCAN, 2 * SCAN + 40), 32'h1);
    rchk("rescan event", kyp_pkg::OFF_IRQ_ST, 32'h2, 32'h2);
    rchk("key buffer", kyp_pkg::OFF_KEYS, 32'h3FFFFFFF, {2'b00, K3});
    chk("irq before mask", {31'h0, irq}, 32'h1);
    wreg(kyp_pkg::OFF_IRQ_EN, 32'h0);
    @(posedge clock);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wreg(kyp_pkg::OFF_CTRL, 32'h6);
    keys <= 30'h0;
    u_host.key_read(w);
    chk("sleep ack word", {1'b0, w}, {2'b01, K3});
    // External source selected while the external clock is still stopped.
    wreg(kyp_pkg::OFF_CTRL, 32'h3);
    keys <= K1;
    wait_low(3000, n);
    chk("no scan without ext clock", 32'(n), 32'd3000);
    osc_run <= 1'b1;
    wait_low(SCAN + 100, n);
    chk("ext scan time", in_win(n, SCAN, SCAN + 30), 32'h1);
    keys <= 30'h0;
    u_host.key_read(w);
    chk("ext key word", {1'b0, w}, {2'b00, K1});
    // Timer polling: the period exceeds rescan plus address plus read time, so the second look, one period in, suffices.
    keys <= K2;
    u_host.timer_poll(2 * SCAN + 1100, 3, n);
    chk("timer poll", 32'(n), 32'd1);
    keys <= 30'h0;
    u_host.key_read(w);
    chk("polled key word", {1'b0, w}, {2'b00, K2});
    rchk("display idle", kyp_pkg::OFF_DISP, 32'hFFFF, 32'h0);
    u_host.disp_refresh(4);
    u_host.disp_refresh(3);
    rchk("display count", kyp_pkg::OFF_DISP, 32'hFFFF, 32'h7);
    summarize();
  end
endmodule : test_kyp_keypad_link
